/* rtl/fnd_pkg.sv */
/*
  fnd_pkg: shared constants and carriers for the fractional-N feedback divider control block.
  Assumes an APB master with 32-bit data; each byte-wide register sits in the low bits of one aligned word.
*/
package fnd_pkg;

  // register indices; byte address is four times the index
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_POWER = 4'h2;
  localparam logic [3:0] REG_MODE = 4'h3;
  localparam logic [3:0] REG_SUPPLY = 4'h4;
  localparam logic [3:0] REG_SEED = 4'h5;
  localparam logic [3:0] REG_DIV_HI = 4'h6;
  localparam logic [3:0] REG_DIV_LO = 4'h7;
  localparam logic [3:0] REG_NUM_HI = 4'h8;
  localparam logic [3:0] REG_NUM_MID = 4'h9;
  localparam logic [3:0] REG_NUM_LO = 4'hA;
  localparam logic [3:0] REG_OUTPUT = 4'hB;
  localparam logic [3:0] REG_PUMP = 4'hD;

  // writable bits per index (index 15 first); zero means not a stored register
  localparam logic [15:0][7:0] WRITE_MASK = {
    8'h00, 8'h00, 8'h24, 8'h00, 8'h1F, 8'hF0, 8'hFF, 8'h3F,
    8'hFF, 8'h03, 8'hFF, 8'h0F, 8'h07, 8'h0A, 8'h00, 8'h00};
  localparam logic [15:0][7:0] RESET_VALUE = {
    8'h00, 8'h00, 8'h24, 8'h00, 8'h19, 8'hF0, 8'hFF, 8'h3F,
    8'hFA, 8'h00, 8'h11, 8'h07, 8'h06, 8'h02, 8'h00, 8'h00};

  // field positions
  localparam int POWER_MODULATOR_POWER_DOWN_BIT = 3;
  localparam int POWER_MUTE_BIT = 1;
  localparam int MODE_AUTO_BIT = 2;
  localparam int MODE_DITHER_BIT = 1;
  localparam int MODE_INT_BIT = 0;
  localparam int SUPPLY_LIN_BIT = 3;
  localparam int SUPPLY_REG_BIT = 2;
  localparam int SUPPLY_VSEL_LSB = 0;
  localparam int NUM_LO_REINIT_BIT = 1;
  localparam int OUTPUT_RFO_LSB = 3;
  localparam int OUTPUT_OD_LSB = 0;
  localparam int PUMP_MID_BIT = 5;
  localparam int PUMP_RST_BIT = 2;

  // divider limits
  localparam logic [9:0] FRAC_N_MIN = 10'h023;
  localparam logic [9:0] FRAC_N_MAX = 10'h3FB;
  localparam logic [9:0] INT_N_MIN = 10'h020;
  localparam logic [9:0] INT_N_MAX = 10'h3FF;
  localparam logic [9:0] RESET_N = 10'h0FA;
  localparam logic [2:0] OD_MIN = 3'h1;
  localparam logic [2:0] OD_MAX = 3'h6;
  localparam int DEN_BITS = 18;
  localparam logic [9:0] LFSR_FILL = 10'h2A5;

  typedef struct packed {
    logic int_mode;
    logic dither;
    logic auto_reinit;
    logic lin_req;
    logic reg_on;
    logic modulator_power_down;
    logic [1:0] vsel;
    logic [7:0] seed;
    logic [9:0] nd;
    logic [17:0] num;
    logic [2:0] od;
    logic [1:0] rfo;
    logic mute;
    logic pump_midrail_bias;
    logic detector_hold_reset;
  } fnd_cfg_s;

  typedef struct packed {
    logic lin_on;
    logic reg_enable;
    logic reg_bypass;
    logic [1:0] vsel;
    logic [1:0] rfo;
    logic rf_mute;
    logic mod_standby;
  } fnd_ana_s;

  localparam fnd_ana_s ANA_RESET = '{lin_on: 1'b0, reg_enable: 1'b1, reg_bypass: 1'b0, vsel: 2'h3,
                                     rfo: 2'h3, rf_mute: 1'b1, mod_standby: 1'b0};

endpackage

/* rtl/fnd_frac_divider.sv */
/*
  fnd_frac_divider: APB register file, feedback divider with first-order delta-sigma modulator and dither,
  output divider with 50% duty, and the analog control levels for linearizer, regulator and output buffer.
  Assumes vco_in is a level synchronous to pclk and sampled well above twice its rate.
*/
`timescale 1ns/1ps

// Summary of operation
// - linearizer output follows its enable bit when set to one
// - integer mode forces the linearizer off regardless of its bit
// - fractional mode feedback ratio kept within 35 to 1019
// - integer mode feedback ratio kept within 32 to 1023
// - ratio taken directly from the split 10-bit field, no offset
// - modulator steps once per divided cycle, updating the ratio each time
// - modulator takes an 18-bit numerator, 0 to 262143
// - fixed denominator 262144: carry when accumulator overflows 18 bits
// - integer mode holds modulator in standby, state kept, resumes at once
// - dither enable bit turns numerator dither on, on after reset
// - programmable seed initialises the dither pseudorandom sequence
// - writing reinit bit restarts modulator state, bit then clears itself
// - auto-reinit set makes any write to indices 5 to 10 set reinit
// - regulator off and bypassed when its enable is zero or power-down set
// - two-bit voltage select passed to regulator, codes 0 to 3
// - output divider divides by 1 to 6 with 50% duty
// - output ratio taken directly from the 3-bit field
// - two-bit output power field passed to the buffer, codes 0 to 3
// - buffer muted when mute bit set or mute pin low
module fnd_frac_divider (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // vco and mute pin
  input wire logic vco_in,
  input wire logic mute_n,
  // divided outputs
  output logic fb_div_pulse,
  output logic [9:0] fb_ratio_now,
  output logic rf_div_out,
  // analog controls
  output fnd_pkg::fnd_ana_s analog_ctrl
);

  logic [7:0] regs [16];
  fnd_pkg::fnd_cfg_s cfg;
  logic [3:0] idx;
  logic hit;
  logic access;
  logic wr_fire;
  logic [7:0] read_byte;
  logic reinit_set;
  logic reinit_pend;
  logic vco_q;
  logic vco_rise;
  logic vco_edge;
  logic [9:0] fb_cnt;
  logic fb_wrap;
  logic [17:0] acc;
  logic [17:0] lfsr;
  logic dith_prev;
  logic dith_now;
  logic [19:0] sum_raw;
  logic [19:0] sum_adj;
  logic carry;
  logic step_en;
  logic [9:0] next_ratio;
  logic [2:0] od_eff;
  logic [2:0] od_cnt;

  // apb decode
  assign idx = paddr[5:2];
  assign access = psel & penable;
  assign hit = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) &&
               ((fnd_pkg::WRITE_MASK[idx] != 8'h00) || (idx == fnd_pkg::REG_STATUS));
  assign wr_fire = access & pready & pwrite & ~pslverr;

  // one wait state keeps pready, prdata and pslverr straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access & ~pready) begin
      pslverr <= ~hit;
      prdata <= (hit & ~pwrite) ? {24'h00_0000, read_byte} : 32'h0000_0000;
    end
  end

  always_comb begin
    if (idx == fnd_pkg::REG_STATUS) begin
      read_byte = {3'h0, analog_ctrl.rf_mute, analog_ctrl.lin_on, reinit_pend,
                   analog_ctrl.reg_enable, analog_ctrl.mod_standby};
    end else if (idx == fnd_pkg::REG_NUM_LO) begin
      read_byte = regs[idx] | {6'h00, reinit_pend, 1'b0};
    end else begin
      read_byte = regs[idx];
    end
  end

  // register file; writes to the status word are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= fnd_pkg::RESET_VALUE[i];
      end
    end else if (wr_fire) begin
      regs[idx] <= pwdata[7:0] & fnd_pkg::WRITE_MASK[idx];
    end
  end

  always_comb begin
    cfg.int_mode = regs[fnd_pkg::REG_MODE][fnd_pkg::MODE_INT_BIT];
    cfg.dither = regs[fnd_pkg::REG_MODE][fnd_pkg::MODE_DITHER_BIT];
    cfg.auto_reinit = regs[fnd_pkg::REG_MODE][fnd_pkg::MODE_AUTO_BIT];
    cfg.lin_req = regs[fnd_pkg::REG_SUPPLY][fnd_pkg::SUPPLY_LIN_BIT];
    cfg.reg_on = regs[fnd_pkg::REG_SUPPLY][fnd_pkg::SUPPLY_REG_BIT];
    cfg.vsel = regs[fnd_pkg::REG_SUPPLY][fnd_pkg::SUPPLY_VSEL_LSB +: 2];
    cfg.modulator_power_down = regs[fnd_pkg::REG_POWER][fnd_pkg::POWER_MODULATOR_POWER_DOWN_BIT];
    cfg.mute = regs[fnd_pkg::REG_POWER][fnd_pkg::POWER_MUTE_BIT];
    cfg.seed = regs[fnd_pkg::REG_SEED];
    cfg.nd = {regs[fnd_pkg::REG_DIV_HI][1:0], regs[fnd_pkg::REG_DIV_LO]};
    cfg.num = {regs[fnd_pkg::REG_NUM_HI][5:0], regs[fnd_pkg::REG_NUM_MID],
               regs[fnd_pkg::REG_NUM_LO][7:4]};
    cfg.od = regs[fnd_pkg::REG_OUTPUT][fnd_pkg::OUTPUT_OD_LSB +: 3];
    cfg.rfo = regs[fnd_pkg::REG_OUTPUT][fnd_pkg::OUTPUT_RFO_LSB +: 2];
    cfg.pump_midrail_bias = regs[fnd_pkg::REG_PUMP][fnd_pkg::PUMP_MID_BIT];
    cfg.detector_hold_reset = regs[fnd_pkg::REG_PUMP][fnd_pkg::PUMP_RST_BIT];
  end

  // modulator restart request; a new request wins over the self-clear
  assign reinit_set = wr_fire & (
    ((idx == fnd_pkg::REG_NUM_LO) & pwdata[fnd_pkg::NUM_LO_REINIT_BIT]) |
    (cfg.auto_reinit & (idx >= fnd_pkg::REG_SEED) & (idx <= fnd_pkg::REG_NUM_LO)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reinit_pend <= 1'b0;
    end else if (reinit_set) begin
      reinit_pend <= 1'b1;
    end else begin
      reinit_pend <= 1'b0;
    end
  end

  // vco edge detection; input is taken as synchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_q <= 1'b0;
    end else begin
      vco_q <= vco_in;
    end
  end

  assign vco_rise = vco_in & ~vco_q;
  assign vco_edge = vco_in ^ vco_q;

  // feedback divider: the wrap marks one phase-detector cycle
  assign fb_wrap = vco_rise && (fb_cnt >= fb_ratio_now - 10'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_cnt <= 10'h000;
    end else if (vco_rise) begin
      fb_cnt <= fb_wrap ? 10'h000 : fb_cnt + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_div_pulse <= 1'b0;
    end else begin
      fb_div_pulse <= fb_wrap;
    end
  end

  // modulator: first-order accumulator, subtractive dither keeps the mean unbiased
  // standby freezes state without clearing it, so fractional mode resumes at once
  assign step_en = ~cfg.int_mode & ~cfg.modulator_power_down;
  assign dith_now = cfg.dither & lfsr[0];
  assign sum_raw = {2'h0, acc} + {2'h0, cfg.num} + {19'h0_0000, dith_now};
  assign sum_adj = (dith_prev && (sum_raw != 20'h0_0000)) ? sum_raw - 20'h0_0001 : sum_raw;
  assign carry = step_en & (sum_adj[19:fnd_pkg::DEN_BITS] != 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 18'h0_0000;
      dith_prev <= 1'b0;
    end else if (reinit_pend) begin
      acc <= 18'h0_0000;
      dith_prev <= 1'b0;
    end else if (fb_wrap && step_en) begin
      acc <= sum_adj[17:0];
      dith_prev <= dith_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr <= {fnd_pkg::LFSR_FILL, fnd_pkg::RESET_VALUE[fnd_pkg::REG_SEED]};
    end else if (reinit_pend) begin
      lfsr <= {fnd_pkg::LFSR_FILL, cfg.seed};
    end else if (fb_wrap && step_en) begin
      lfsr <= {lfsr[16:0], lfsr[17] ^ lfsr[10]};
    end
  end

  // ratio limits depend on the mode; out-of-range values are pinned to the edge
  function automatic logic [9:0] clamp_ratio(input logic [10:0] n, input logic int_mode);
    logic [9:0] lo;
    logic [9:0] hi;
    lo = int_mode ? fnd_pkg::INT_N_MIN : fnd_pkg::FRAC_N_MIN;
    hi = int_mode ? fnd_pkg::INT_N_MAX : fnd_pkg::FRAC_N_MAX;
    if (n < {1'b0, lo}) begin
      clamp_ratio = lo;
    end else if (n > {1'b0, hi}) begin
      clamp_ratio = hi;
    end else begin
      clamp_ratio = n[9:0];
    end
  endfunction

  assign next_ratio = clamp_ratio({1'b0, cfg.nd} + {10'h000, carry}, cfg.int_mode);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_ratio_now <= fnd_pkg::RESET_N;
    end else if (fb_wrap) begin
      fb_ratio_now <= next_ratio;
    end
  end

  // output divider counts both vco edges, so odd ratios still give 50% duty
  always_comb begin
    if (cfg.od < fnd_pkg::OD_MIN) begin
      od_eff = fnd_pkg::OD_MIN;
    end else if (cfg.od > fnd_pkg::OD_MAX) begin
      od_eff = fnd_pkg::OD_MAX;
    end else begin
      od_eff = cfg.od;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_cnt <= 3'h0;
      rf_div_out <= 1'b0;
    end else if (vco_edge) begin
      if (od_cnt >= od_eff - 3'h1) begin
        od_cnt <= 3'h0;
        rf_div_out <= ~rf_div_out;
      end else begin
        od_cnt <= od_cnt + 3'h1;
      end
    end
  end

  // analog levels; linearizer does not look at detector reset or midrail bias
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_ctrl <= fnd_pkg::ANA_RESET;
    end else begin
      analog_ctrl.lin_on <= cfg.lin_req & ~cfg.int_mode;
      analog_ctrl.reg_enable <= cfg.reg_on & ~cfg.modulator_power_down;
      analog_ctrl.reg_bypass <= ~cfg.reg_on | cfg.modulator_power_down;
      analog_ctrl.vsel <= cfg.vsel;
      analog_ctrl.rfo <= cfg.rfo;
      analog_ctrl.rf_mute <= cfg.mute | ~mute_n;
      analog_ctrl.mod_standby <= cfg.int_mode;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_auto_write;
    wr_fire && cfg.auto_reinit && (idx >= fnd_pkg::REG_SEED) && (idx <= fnd_pkg::REG_NUM_LO);
  endsequence

  sequence s_restart_done;
    (acc == 18'h0_0000) ##1 !reinit_pend;
  endsequence

  a_lin_int_off: assert property (cfg.int_mode |=> !analog_ctrl.lin_on)
    else $error("linearizer on in integer mode");
  a_lin_follow: assert property (!cfg.int_mode && cfg.lin_req |=> analog_ctrl.lin_on)
    else $error("linearizer not following enable");
  a_ratio_frac: assert property (fb_wrap && !cfg.int_mode |=>
      fb_ratio_now >= fnd_pkg::FRAC_N_MIN && fb_ratio_now <= fnd_pkg::FRAC_N_MAX)
    else $error("fractional ratio out of range");
  a_ratio_int: assert property (fb_wrap && cfg.int_mode && $stable(cfg.nd) |=>
      fb_ratio_now >= fnd_pkg::INT_N_MIN &&
      ($past(cfg.nd) < fnd_pkg::INT_N_MIN || fb_ratio_now == $past(cfg.nd)))
    else $error("integer ratio not taken from field");
  a_mod_standby: assert property (cfg.int_mode && !reinit_pend |=> $stable(acc) && $stable(lfsr))
    else $error("modulator moved in standby");
  a_reinit_clear: assert property (reinit_pend && !reinit_set |=> s_restart_done)
    else $error("modulator restart did not complete");
  a_auto_reinit: assert property (s_auto_write |=> reinit_pend)
    else $error("auto restart missed");
  a_reg_bypass: assert property ((!cfg.reg_on || cfg.modulator_power_down) |=>
      !analog_ctrl.reg_enable && analog_ctrl.reg_bypass)
    else $error("regulator not bypassed");
  a_out_mute: assert property (!mute_n |=> analog_ctrl.rf_mute)
    else $error("output not muted by pin");
  a_od_count: assert property (vco_edge && $stable(od_eff) && od_cnt == od_eff - 3'h1 |=>
      rf_div_out != $past(rf_div_out) && od_cnt == 3'h0)
    else $error("output divider did not toggle at ratio");

  // apb handshake: one wait state, answer lasts one cycle
  a_pready_wait: assert property (access && !pready |=> pready)
    else $error("pready missing after wait state");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");

  // feedback divider and modulator steps
  sequence s_wrap_step;
    fb_wrap && step_en && !reinit_pend;
  endsequence

  a_pulse_follow: assert property (fb_wrap |=> fb_div_pulse)
    else $error("divider pulse missing after wrap");
  a_pulse_only: assert property (!fb_wrap |=> !fb_div_pulse)
    else $error("divider pulse without wrap");
  a_ratio_hold: assert property (!fb_wrap |=> $stable(fb_ratio_now))
    else $error("ratio changed between wraps");
  a_frac_direct: assert property (fb_wrap && !cfg.int_mode && !carry &&
      cfg.nd >= fnd_pkg::FRAC_N_MIN && cfg.nd <= fnd_pkg::FRAC_N_MAX |=> fb_ratio_now == $past(cfg.nd))
    else $error("ratio not taken from field");
  a_carry_step: assert property (fb_wrap && carry && cfg.nd >= fnd_pkg::FRAC_N_MIN &&
      cfg.nd < fnd_pkg::FRAC_N_MAX |=> fb_ratio_now == $past(cfg.nd) + 10'h001)
    else $error("carry did not add one to ratio");
  a_acc_step: assert property (s_wrap_step |=> acc == $past(sum_adj[17:0]))
    else $error("accumulator step wrong");
  a_dither_off: assert property (!cfg.dither |-> !dith_now)
    else $error("dither active while disabled");
  a_seed_load: assert property (reinit_pend |=> lfsr == {fnd_pkg::LFSR_FILL, $past(cfg.seed)})
    else $error("dither sequence not seeded");
  a_reinit_self: assert property (reinit_pend && !reinit_set |=> !reinit_pend)
    else $error("restart request did not clear itself");

  // analog levels follow the configuration one cycle later
  a_standby_flag: assert property (1'b1 |=> analog_ctrl.mod_standby == $past(cfg.int_mode))
    else $error("standby flag not following mode");
  a_reg_enable: assert property (cfg.reg_on && !cfg.modulator_power_down |=>
      analog_ctrl.reg_enable && !analog_ctrl.reg_bypass)
    else $error("regulator not enabled");
  a_vsel_pass: assert property (1'b1 |=> analog_ctrl.vsel == $past(cfg.vsel))
    else $error("voltage select not passed on");
  a_rfo_pass: assert property (1'b1 |=> analog_ctrl.rfo == $past(cfg.rfo))
    else $error("output power not passed on");
  a_mute_bit: assert property (cfg.mute |=> analog_ctrl.rf_mute)
    else $error("output not muted by bit");
  a_od_range: assert property (od_eff >= fnd_pkg::OD_MIN && od_eff <= fnd_pkg::OD_MAX)
    else $error("output ratio outside one to six");

endmodule

/* testbench/fnd_vco_model.sv */
/*
  fnd_vco_model: stand-in for the external oscillator that feeds the feedback divider input.
  Assumes the divider samples vco_in on pclk, so every level is held a whole number of cycles.
*/
`timescale 1ns/1ps
module fnd_vco_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [3:0] half,
  // oscillator level
  output logic vco_in
);
  logic [3:0] cnt;

  // levels move only on pclk: a half period below one cycle cannot be made, which the divider needs anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      vco_in <= 1'b0;
    end else if (run) begin
      if (cnt + 4'h1 >= half) begin
        cnt <= 4'h0;
        vco_in <= ~vco_in;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

/* testbench/fractional_n_divider_control_tb_top.sv */
/*
  fractional_n_divider_control_tb_top: self-checking bench for fnd_frac_divider with an APB master,
  a shadow register model and an oscillator model. Assumes a 50 MHz pclk and asynchronous low reset.
*/
`timescale 1ns/1ps
module fractional_n_divider_control_tb_top;
  logic pclk, presetn, psel, penable, pwrite, mute_n, run, vco_in;
  logic pready, pslverr, err, fb_div_pulse, rf_div_out;
  logic [3:0] half;
  logic [7:0] paddr;
  logic [8:0] amask;
  logic [9:0] fb_ratio_now;
  logic [31:0] pwdata, prdata, rd;
  fnd_pkg::fnd_ana_s analog_ctrl, exp_ana;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed, s, c, hi, lo;
  int shadow [16];
  // readable bits per index; zero marks an empty slot or the status word at index 0
  int rmask [16] = '{0, 0, 8'h0A, 8'h07, 8'h0F, 8'hFF, 8'h03, 8'hFF, 8'h3F, 8'hFF, 8'hF0, 8'h1F, 0, 8'h24, 0, 0};
  int rst_val [16] = '{8'h12, 0, 8'h02, 8'h06, 8'h07, 8'h11, 0, 8'hFA, 8'h3F, 8'hFF, 8'hF0, 8'h19, 0, 8'h24, 0, 0};
  // integer mode, programmed ratio, ratio in force
  int div_tab [5][3] = '{'{1, 20, 32}, '{1, 1023, 1023}, '{1, 300, 300}, '{0, 34, 35}, '{0, 1020, 1019}};

  fnd_frac_divider u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .vco_in(vco_in),
    .mute_n(mute_n), .fb_div_pulse(fb_div_pulse), .fb_ratio_now(fb_ratio_now), .rf_div_out(rf_div_out),
    .analog_ctrl(analog_ctrl));
  fnd_vco_model u_vco (.pclk(pclk), .presetn(presetn), .run(run), .half(half), .vco_in(vco_in));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held from setup until pready is sampled high
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    apb(1'b1, i[3:0], d);
    shadow[i] = d & rmask[i];
  endtask

  task automatic rc(input int i);
    apb(1'b0, i[3:0], 8'h00);
    chk(rd, shadow[i]);
    chk({31'h0, err}, (rmask[i] == 0 && i != 0) ? 1 : 0);
  endtask

  task automatic wait_rf(input logic v);
    do @(posedge pclk); while (rf_div_out !== v);
  endtask

  // sums ratios and cycles over n divisions, after two wraps let a new ratio settle
  task automatic div_meas(input int n);
    s = 0;
    c = 0;
    repeat (2) begin
      do @(posedge pclk); while (fb_div_pulse !== 1'b1);
    end
    for (int k = 0; k < n; k++) begin
      s += fb_ratio_now;
      do begin
        @(posedge pclk);
        c++;
      end while (fb_div_pulse !== 1'b1);
    end
  endtask

  function automatic fnd_pkg::fnd_ana_s model_ana();
    fnd_pkg::fnd_ana_s a;
    a.lin_on = shadow[4][3] & ~shadow[3][0];
    a.reg_enable = shadow[4][2] & ~shadow[2][3];
    a.reg_bypass = ~a.reg_enable;
    a.vsel = shadow[4][1:0];
    a.rfo = shadow[11][4:3];
    a.rf_mute = shadow[2][1] | ~mute_n;
    a.mod_standby = shadow[3][0];
    return a;
  endfunction

  initial begin
    seed = 32'hEB1705BB;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mute_n = 1'b1;
    run = 1'b0;
    half = 4'h2;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    run <= 1'b1;
    shadow = rst_val;
    for (int i = 0; i < 16; i++) rc(i);
    $display("test reset_values done");
    for (int i = 0; i < 16; i++) wr(i, 8'($random(seed)));
    for (int i = 1; i < 16; i++) rc(i);
    $display("test register_access done");
    wr(13, 8'h00);
    for (int t = 0; t < 24; t++) begin
      wr(2, 8'($random(seed)));
      wr(3, 8'($random(seed)));
      wr(4, 8'($random(seed)));
      wr(11, 8'($random(seed)));
      mute_n <= 1'($random(seed));
      repeat (3) @(posedge pclk);
      exp_ana = model_ana();
      // power-down may also freeze the modulator, so standby is not judged then
      amask = shadow[2][3] ? 9'h1FE : 9'h1FF;
      chk(32'(analog_ctrl & amask), 32'(exp_ana & amask));
    end
    $display("test analog_controls done");
    wr(2, 8'h00);
    wr(8, 8'h00);
    wr(9, 8'h00);
    wr(10, 8'h12);
    rc(10);
    for (int t = 0; t < 5; t++) begin
      wr(3, 8'(div_tab[t][0]));
      wr(6, 8'(div_tab[t][1] >> 8));
      wr(7, 8'(div_tab[t][1]));
      div_meas(2);
      chk(s, 2 * div_tab[t][2]);
      chk(c, 4 * s);
    end
    $display("test ratio_limits done");
    wr(3, 8'h04);
    wr(6, 8'h00);
    wr(7, 8'h28);
    wr(8, 8'h10);
    wr(10, 8'h00);
    div_meas(16);
    chk(s, 644);
    chk(c, 4 * s);
    $display("test fractional_average done");
    for (int o = 1; o < 7; o++) begin
      wr(11, 8'(o));
      wait_rf(1'b0);
      wait_rf(1'b1);
      wait_rf(1'b0);
      wait_rf(1'b1);
      hi = 0;
      lo = 0;
      do begin
        @(posedge pclk);
        hi++;
      end while (rf_div_out === 1'b1);
      do begin
        @(posedge pclk);
        lo++;
      end while (rf_div_out === 1'b0);
      chk(hi, 2 * o);
      chk(lo, 2 * o);
    end
    $display("test output_divider done");
    print_verdict();
  end
endmodule
